/* bench/frame_index_irq_asserts.sv */
// port-level checks for the frame index and interrupt block
`timescale 1ns/1ps
`default_nettype none
module frame_index_irq_asserts #(
  parameter int unsigned MICROFRAME_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic bvalid,
  input wire logic port_change_event,
  input wire logic irq,
  input wire logic microframe_start,
  input wire frame_pkg::run_ctrl_s run_ctrl,
  input wire frame_pkg::frame_out_s frame_out
);
  import frame_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic [9:0] entry;
  // entry selector for the list size in force
  always_comb
  begin
    case (run_ctrl.frame_list_size)
      list_512: entry = {1'h0, frame_out.frame_index[11:3]};
      list_256: entry = {2'h0, frame_out.frame_index[10:3]};
      default: entry = frame_out.frame_index[12:3];
    endcase
  end
  AST_RST_CLEAR: assert property ($rose(rstn) |-> !irq && frame_out == '0)
    else $error("outputs not clear after reset");
  AST_STEP: assert property (microframe_start |=>
    frame_out.frame_index == $past(frame_out.frame_index) + 14'h1)
    else $error("index did not step by one");
  AST_PERIOD: assert property (microframe_start |-> ##MICROFRAME_CYCLES
    (microframe_start || !run_ctrl.run_stop_control))
    else $error("microframe period wrong");
  AST_PULSE: assert property (microframe_start |=> !microframe_start)
    else $error("microframe pulse too long");
  AST_STOPPED: assert property (!run_ctrl.run_stop_control [*3] |-> !microframe_start)
    else $error("tick while stopped");
  AST_IRQ_RISE: assert property ($rose(irq) |->
    $past(port_change_event, 2) || $past(bvalid) || $past(microframe_start))
    else $error("irq rose without cause");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(bvalid))
    else $error("irq fell without a write");
  AST_ENTRY: assert property ($stable(run_ctrl) && $stable(frame_out.frame_index) |->
    frame_out.list_entry_index == entry)
    else $error("list entry index wrong");
  AST_SOF: assert property (frame_out.sof_frame_number == frame_out.frame_index[13:3])
    else $error("sof number wrong");
  cover property (microframe_start);
  cover property ($rose(irq));
  cover property ($fell(irq));
endmodule
`default_nettype wire

/* bench/frame_index_irq_bench.sv */
// self-checking bench for the frame index and interrupt block
`timescale 1ns/1ps
`default_nettype none
module frame_index_irq_bench;
  import frame_pkg::*;
  localparam int MF = 20;
  logic mclk, rstn, awvalid, wvalid, bready, arvalid, rready, port_change_event;
  logic awready, wready, bvalid, arready, rvalid, irq, microframe_start;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  run_ctrl_s run_ctrl;
  frame_out_s frame_out;
  int bad_count, compares, cyc;

  frame_index_irq #(.MICROFRAME_CYCLES(MF)) u_frame_index_irq (
    .mclk, .rstn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .port_change_event, .irq, .microframe_start, .run_ctrl, .frame_out);

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic stop_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, s, e);
    end
  endtask

  // bounded wait; running out ends the run
  task automatic lim(input int n);
    if (n >= 50)
    begin
      bad_count++;
      stop_test();
    end
  endtask

  // one write, channels released as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end
    while (bvalid !== 1'b1 && n < 50);
    resp = bresp;
    bready <= 1'b0;
    lim(n);
  endtask

  task automatic rdw(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end
    while (rvalid !== 1'b1 && n < 50);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    lim(n);
  endtask

  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic pulse();
    @(posedge mclk);
    port_change_event <= 1'b1;
    @(posedge mclk);
    port_change_event <= 1'b0;
    settle();
  endtask

  // edges until the next microframe pulse
  task automatic wait_mf();
    cyc = 0;
    do
    begin
      @(posedge mclk);
      cyc++;
    end
    while (microframe_start !== 1'b1 && cyc < 50);
    // frame_out takes the new index only at this edge
    #1;
    lim(cyc);
  endtask

  task automatic s_reset();
    rdw(8'h94);
    chk(rd, 32'h0);
    rdw(8'h98);
    chk(rd, 32'h0);
    rdw(8'h40);
    chk(rd, 32'h0);
    chk(resp, 2'h2);
    wr(8'h40, 32'h1, 4'hF);
    chk(resp, 2'h2);
  endtask

  task automatic s_irq();
    wr(8'h94, 32'h4, 4'hF);
    rdw(8'h94);
    chk(rd, 32'h4);
    chk(resp, 2'h0);
    pulse();
    chk(irq, 1'b1);
    wr(8'h90, 32'h0, 4'hF);
    settle();
    chk(irq, 1'b1);
    wr(8'h90, 32'h4, 4'hF);
    settle();
    chk(irq, 1'b0);
    wr(8'h94, 32'h0, 4'hF);
    pulse();
    chk(irq, 1'b0);
    rdw(8'h90);
    chk(rd, 32'h4);
    wr(8'h94, 32'h4, 4'hF);
    settle();
    chk(irq, 1'b1);
    wr(8'h90, 32'h4, 4'hF);
    rdw(8'h90);
    chk(rd, 32'h0);
  endtask

  task automatic s_index();
    logic [31:0] v;
    wr(8'h98, 32'h3FF8, 4'hF);
    wr(8'h98, 32'h1234, 4'h3);
    chk(resp, 2'h0);
    rdw(8'h98);
    chk(rd, 32'h3FF8);
    chk(frame_out.sof_frame_number, 11'h7FF);
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h8C, 32'(s) << 2, 4'hF);
      settle();
      chk(frame_out.list_entry_index, s == 1 ? 10'h1FF : s == 2 ? 10'h0FF : 10'h3FF);
    end
    wr(8'h94, 32'h8, 4'hF);
    wr(8'h98, 32'h07FE, 4'hF);
    wr(8'h8C, 32'h9, 4'hF);
    chk(run_ctrl, 32'h5);
    wait_mf();
    chk(frame_out.frame_index, 14'h07FF);
    chk(irq, 1'b0);
    wait_mf();
    chk(cyc, MF);
    chk(frame_out.frame_index, 14'h0800);
    chk(irq, 1'b1);
    wr(8'h8C, 32'h8, 4'hF);
    rdw(8'h98);
    v = rd;
    repeat (60) @(posedge mclk);
    rdw(8'h98);
    chk(rd, v);
    rdw(8'h90);
    chk(rd, 32'h8);
    wr(8'h90, 32'h8, 4'hF);
    settle();
    chk(irq, 1'b0);
  endtask

  initial
  begin
    {rstn, awvalid, wvalid, bready, arvalid, rready, port_change_event} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    s_reset();
    s_irq();
    s_index();
    stop_test();
  end
endmodule

bind frame_index_irq frame_index_irq_asserts #(.MICROFRAME_CYCLES(MICROFRAME_CYCLES)) u_chk (
  .mclk(mclk), .rstn(rstn), .bvalid(bvalid), .port_change_event(port_change_event),
  .irq(irq), .microframe_start(microframe_start), .run_ctrl(run_ctrl), .frame_out(frame_out));
`default_nettype wire

/* verilog/frame_index_irq.sv */
// frame index counter and host interrupt enable with an AXI4-Lite slave
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "frame_regs.svh"

// What this block does
// - an enabled rollover flag (enable bit 3) raises the host interrupt.
// - an enabled port change flag (enable bit 2) raises the host interrupt.
// - clearing a status flag acknowledges and drops its interrupt source.
// - the frame index is updated once per 125 us microframe.
// - frame index bits from 3 up to a size-set top bit select the list entry.
// - a written frame index carries into the SOF frame numbers that follow.
// - the frame index is a 14-bit field in bits 13 to 0.
// - the frame index increments by one at the end of each microframe.
// - the rollover flag sets when the index wraps at the size-set point.
// - a one written to a status flag clears it, a zero leaves it.
// - the frame index advances only while run is selected.
module frame_index_irq #(
  parameter int unsigned MICROFRAME_CYCLES = `MICROFRAME_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [`ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic port_change_event,
  output logic irq,
  output logic microframe_start,
  output frame_pkg::run_ctrl_s run_ctrl,
  output frame_pkg::frame_out_s frame_out
);
  import frame_pkg::*;

  logic aw_held;
  logic w_held;
  logic [`ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic do_write;
  logic wr_mapped;
  logic wr_ctrl;
  logic wr_status;
  logic wr_enable;
  logic wr_frame;
  logic tick;
  logic wrap;
  logic rollover_event;
  logic [`FRIDX_W-1:0] frame_index;
  logic [`FRIDX_W-1:0] next_frame_index;
  logic [`FRIDX_W-1:0] wrap_mask;
  logic [`FLR_BIT:`PCD_BIT] events;
  logic [`FLR_BIT:`PCD_BIT] flags;
  logic [`FLR_BIT:`PCD_BIT] enables;
  logic [31:0] read_word;
  logic rd_mapped;

  // reset images of the two software words; only their defined fields are kept
  localparam logic [31:0] RUN_CONTROL_RESET = `RST_RUN_CONTROL;
  localparam logic [31:0] IRQ_ENABLE_RESET = `RST_IRQ_ENABLE;

  // write address channel, held until the response is taken
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      aw_held <= 1'b0;
      awready <= 1'b1;
      wr_addr <= 8'h00;
    end
    else if (awvalid && awready)
    begin
      aw_held <= 1'b1;
      awready <= 1'b0;
      wr_addr <= awaddr;
    end
    else if (bvalid && bready)
    begin
      aw_held <= 1'b0;
      awready <= 1'b1;
    end
  end

  // write data channel, taken in either order against the address
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      w_held <= 1'b0;
      wready <= 1'b1;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end
    else if (wvalid && wready)
    begin
      w_held <= 1'b1;
      wready <= 1'b0;
      wr_data <= wdata;
      wr_strb <= wstrb;
    end
    else if (bvalid && bready)
    begin
      w_held <= 1'b0;
      wready <= 1'b1;
    end
  end

  // the write lands once both halves are held and no response is pending
  assign do_write = aw_held && w_held && !bvalid;
  assign wr_mapped = (wr_addr == `OFS_RUN_CONTROL) || (wr_addr == `OFS_HOST_STATUS)
    || (wr_addr == `OFS_IRQ_ENABLE) || (wr_addr == `OFS_FRAME_INDEX);
  // all control fields sit in byte lane 0
  assign wr_ctrl = do_write && wr_strb[0] && (wr_addr == `OFS_RUN_CONTROL);
  assign wr_status = do_write && wr_strb[0] && (wr_addr == `OFS_HOST_STATUS);
  assign wr_enable = do_write && wr_strb[0] && (wr_addr == `OFS_IRQ_ENABLE);
  // partial words are dropped so the counter never holds a torn value
  assign wr_frame = do_write && (wr_strb == `STRB_FULL)
    && (wr_addr == `OFS_FRAME_INDEX);

  // write response, an error for holes in the map
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid <= 1'b1;
      bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (bready)
    begin
      bvalid <= 1'b0;
    end
  end

  // run control and frame list size; reserved bits are not stored
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      run_ctrl.run_stop_control <= RUN_CONTROL_RESET[`RUN_BIT];
      run_ctrl.frame_list_size <= frame_list_size_e'(RUN_CONTROL_RESET[`SIZE_MSB:`SIZE_LSB]);
    end
    else if (wr_ctrl)
    begin
      run_ctrl.run_stop_control <= wr_data[`RUN_BIT];
      run_ctrl.frame_list_size <= frame_list_size_e'(wr_data[`SIZE_MSB:`SIZE_LSB]);
    end
  end

  // interrupt enables; reserved bits are not stored, so they read zero
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      enables <= IRQ_ENABLE_RESET[`FLR_BIT:`PCD_BIT];
    end
    else if (wr_enable)
    begin
      enables <= wr_data[`FLR_BIT:`PCD_BIT];
    end
  end

  // microframe pacing, held in reset while stopped
  microframe_timer #(
    .CYCLES(MICROFRAME_CYCLES)
  ) u_timer (
    .mclk(mclk),
    .rstn(rstn),
    .run(run_ctrl.run_stop_control),
    .tick(tick)
  );

  // wrap point follows the list size; the spare code acts as 1024
  always_comb
  begin
    unique case (run_ctrl.frame_list_size)
      list_512: wrap_mask = `WRAP_MASK_512;
      list_256: wrap_mask = `WRAP_MASK_256;
      list_1024, list_rsvd: wrap_mask = `WRAP_MASK_1024;
    endcase
  end

  assign next_frame_index = frame_index + 14'h0001;
  assign wrap = (next_frame_index & wrap_mask) == 14'h0000;
  // a software write in the same cycle as a tick wins and hides that wrap
  assign rollover_event = tick && !wr_frame && wrap;

  // frame index counter
  // no tick arrives while stopped, so the index holds its value then
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      frame_index <= `RST_FRAME_INDEX;
    end
    else if (wr_frame)
    begin
      // a write while running is accepted as is; the result is not defined
      frame_index <= wr_data[`FRIDX_MSB:0];
    end
    else if (tick)
    begin
      frame_index <= next_frame_index;
    end
  end

  assign events[`FLR_BIT] = rollover_event;
  assign events[`PCD_BIT] = port_change_event;

  // sticky status flags; a new event beats a clear in the same cycle
  generate
    for (genvar i = `PCD_BIT; i <= `FLR_BIT; i++)
    begin : g_flag
      always_ff @(posedge mclk)
      begin
        if (!rstn)
        begin
          flags[i] <= 1'b0;
        end
        else if (events[i])
        begin
          flags[i] <= 1'b1;
        end
        else if (wr_status && wr_data[i])
        begin
          flags[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // one level request while any enabled flag stands
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= (flags[`FLR_BIT] && enables[`FLR_BIT])
        || (flags[`PCD_BIT] && enables[`PCD_BIT]);
    end
  end

  // microframe pulse; it leads the new index on frame_out by one cycle
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      microframe_start <= 1'b0;
    end
    else
    begin
      microframe_start <= tick;
    end
  end

  // frame outputs toward the schedule and SOF generator, one cycle behind
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      frame_out <= '0;
    end
    else
    begin
      frame_out.frame_index <= frame_index;
      frame_out.sof_frame_number <= frame_index[`FRIDX_MSB:`ENTRY_LSB];
      unique case (run_ctrl.frame_list_size)
        list_512: frame_out.list_entry_index <= {1'b0, frame_index[11:`ENTRY_LSB]};
        list_256: frame_out.list_entry_index <= {2'b00, frame_index[10:`ENTRY_LSB]};
        list_1024, list_rsvd: frame_out.list_entry_index <= frame_index[12:`ENTRY_LSB];
      endcase
    end
  end

  // read multiplexer; reserved bits read as zero
  always_comb
  begin
    read_word = 32'h0000_0000;
    rd_mapped = 1'b1;
    unique case (araddr)
      `OFS_RUN_CONTROL:
      begin
        read_word[`RUN_BIT] = run_ctrl.run_stop_control;
        read_word[`SIZE_MSB:`SIZE_LSB] = run_ctrl.frame_list_size;
      end
      `OFS_HOST_STATUS: read_word[`FLR_BIT:`PCD_BIT] = flags;
      `OFS_IRQ_ENABLE: read_word[`FLR_BIT:`PCD_BIT] = enables;
      `OFS_FRAME_INDEX: read_word[`FRIDX_MSB:0] = frame_index;
      default: rd_mapped = 1'b0;
    endcase
  end

  // read channel, one read at a time
  // the address is decoded live at the handshake edge, so no copy of it is kept
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= read_word;
      rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

/* verilog/frame_pkg.sv */
// types shared by the frame index and interrupt enable block
package frame_pkg;

  // frame list size encodings
  typedef enum logic [1:0] {
    list_1024 = 2'b00,
    list_512 = 2'b01,
    list_256 = 2'b10,
    list_rsvd = 2'b11
  } frame_list_size_e;

  // software run controls
  typedef struct packed {
    frame_list_size_e frame_list_size;
    logic run_stop_control;
  } run_ctrl_s;

  // periodic schedule outputs toward the schedule engine
  typedef struct packed {
    logic [13:0] frame_index;
    logic [10:0] sof_frame_number;
    logic [9:0] list_entry_index;
  } frame_out_s;

endpackage

/* verilog/frame_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef FRAME_REGS_SVH
`define FRAME_REGS_SVH

// register byte offsets on the 8-bit register bus address
`define ADDR_W 8
`define OFS_RUN_CONTROL 8'h8C
`define OFS_HOST_STATUS 8'h90
`define OFS_IRQ_ENABLE 8'h94
`define OFS_FRAME_INDEX 8'h98

// run control register fields
`define RUN_BIT 0
`define SIZE_LSB 2
`define SIZE_MSB 3

// status and enable fields share one layout
`define PCD_BIT 2
`define FLR_BIT 3

// frame index field
`define FRIDX_W 14
`define FRIDX_MSB 13
`define ENTRY_LSB 3
`define ENTRY_W 10
`define SOF_W 11

// wrap masks of the frame index per list size
`define WRAP_MASK_1024 14'h1FFF
`define WRAP_MASK_512 14'h0FFF
`define WRAP_MASK_256 14'h07FF

// reset values
`define RST_RUN_CONTROL 32'h0000_0000
`define RST_IRQ_ENABLE 32'h0000_0000
`define RST_FRAME_INDEX 14'h0000

// microframe period and clock period in ns
`define MICROFRAME_NS 125000
`define MCLK_PERIOD_NS 5
`define MICROFRAME_CYCLES (`MICROFRAME_NS / `MCLK_PERIOD_NS)

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define STRB_FULL 4'hF

`endif

/* verilog/microframe_timer.sv */
// microframe period counter giving one tick every microframe
`timescale 1ns/1ps
`default_nettype none

module microframe_timer #(
  parameter int unsigned CYCLES = 25000
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic run,
  output logic tick
);

  logic [31:0] count;

  // counter restarts whenever the schedule is stopped
  always_ff @(posedge mclk)
  begin
    if (!rstn || !run)
    begin
      count <= 32'h0000_0000;
      tick <= 1'b0;
    end
    else if (count == 32'(CYCLES - 1))
    begin
      count <= 32'h0000_0000;
      tick <= 1'b1;
    end
    else
    begin
      count <= count + 32'h0000_0001;
      tick <= 1'b0;
    end
  end

endmodule

`default_nettype wire
